// ==== verilog/stxf_top.v ====
// transmit fabric write path, segment former, status return and config slave
// assumes fabric pins and reference clock are asynchronous to clk_sys_i
`timescale 1ns/1ns
`default_nettype none
`include "stxf_regs.vh"
module stxf_top #(
	parameter DATA_W = 128
) (
	input  wire                       clk_sys_i,
	input  wire                       reset_i,
	// avalon-mm slave
	input  wire [`STXF_ADDR_W-1:0]    av_address_i,
	input  wire                       av_read_i,
	input  wire                       av_write_i,
	input  wire [31:0]                av_writedata_i,
	input  wire [3:0]                 av_byteenable_i,
	output reg  [31:0]                av_readdata_o,
	output reg                        av_waitrequest_o,
	// fabric write side
	input  wire                       fab_clk_i,
	input  wire                       fab_wr_i,
	input  wire [DATA_W-1:0]          fab_data_i,
	input  wire [DATA_W/8-1:0]        byte_enable_lanes_i,
	input  wire                       fab_sop_i,
	input  wire                       end_of_packet_flag_i,
	input  wire                       fab_err_i,
	output wire                       fab_ready_o,
	// segment stream towards the line
	output reg                        tx_valid_o,
	input  wire                       tx_ready_i,
	output reg  [DATA_W-1:0]          tx_data_o,
	output reg  [DATA_W/8-1:0]        tx_be_o,
	output reg                        tx_sop_o,
	output reg                        tx_eop_o,
	output reg                        tx_err_o,
	output reg                        tx_sos_o,
	output reg                        tx_eos_o,
	// status return
	input  wire                       tx_reference_clock_i,
	output reg                        tx_ref_clk_buf_o,
	output reg  [7:0]                 serviced_port_id_o,
	output reg  [1:0]                 port_fifo_state_o,
	output reg  [3:0]                 port_segment_units_o,
	// low-rate clocking control
	output reg                        pll_hold_pin_o,
	output reg                        pll_bypass_o
);
	localparam BE_W  = DATA_W / 8;
	localparam WORD_W = DATA_W + BE_W + 3;
	localparam integer BEATS_INT = `STXF_UNIT_BITS / DATA_W;
	localparam integer RATE_INT  = `STXF_QUARTER_DIV - 1;
	localparam [6:0] BEATS_PER_UNIT = BEATS_INT[6:0];
	localparam [1:0] RATE_LAST = RATE_INT[1:0];

	// configuration and status state
	reg                    low_speed_select_reg;
	reg                    min_burst_reg;
	reg  [3:0]             burst_units_reg;
	reg  [7:0]             port_id_reg;
	reg                    overrun_reg;
	reg  [7:0]             short_cnt_reg;

	// fabric pin synchronisers
	reg                    fclk_s1_reg;
	reg                    fclk_s2_reg;
	reg                    fclk_s3_reg;
	reg  [WORD_W:0]        fin_s1_reg;
	reg  [WORD_W:0]        fin_s2_reg;
	reg                    cap_valid_reg;
	reg  [WORD_W-1:0]      cap_word_reg;

	// reference clock synchroniser
	reg                    rclk_s1_reg;
	reg                    rclk_s2_reg;

	// segment former
	reg  [1:0]             rate_cnt_reg;
	reg  [6:0]             beat_cnt_reg;
	wire                   buf_in_ready;
	wire                   buf_out_valid;
	wire [WORD_W-1:0]      buf_out_data;
	wire [1:0]             buf_fill;
	wire                   rate_tick;
	wire                   out_free;
	wire                   load;
	wire [6:0]             seg_beats;
	wire                   seg_end;
	wire                   cut_short;
	wire                   fclk_fall;
	wire                   rclk_fall;

	// register bus decode
	wire                   req;
	wire                   wr_take;
	wire [`STXF_ADDR_W-1:0] a_low_speed;
	wire [`STXF_ADDR_W-1:0] a_tx_ctrl;
	wire [`STXF_ADDR_W-1:0] a_burst;
	wire [`STXF_ADDR_W-1:0] a_port;
	wire [`STXF_ADDR_W-1:0] a_status;
	wire                   ovr_set;
	wire                   ovr_clr;
	reg  [31:0]            rd_mux;
	reg  [1:0]             fifo_state;

	assign a_low_speed = {`STXF_IDX_LOW_SPEED, 2'h0};
	assign a_tx_ctrl   = {`STXF_IDX_TX_CTRL, 2'h0};
	assign a_burst     = {`STXF_IDX_BURST, 2'h0};
	assign a_port      = {`STXF_IDX_PORT, 2'h0};
	assign a_status    = {`STXF_IDX_STATUS, 2'h0};

	// one wait state: request seen with waitrequest high, answered next edge
	assign req     = av_read_i | av_write_i;
	assign wr_take = av_write_i & ~av_waitrequest_o;

	always @(posedge clk_sys_i) begin
		if (reset_i)
			av_waitrequest_o <= 1'b1;
		else
			av_waitrequest_o <= ~(req & av_waitrequest_o);
	end

	always @* begin
		fifo_state = `STXF_FS_STARVING;
		if (buf_fill == 2'h2)
			fifo_state = `STXF_FS_SATISFIED;
		else if (buf_fill == 2'h1)
			fifo_state = `STXF_FS_HUNGRY;
	end

	always @* begin
		rd_mux = 32'h0;
		if (av_address_i == a_low_speed) begin
			rd_mux[`STXF_LOW_SPEED_BIT] = low_speed_select_reg;
		end else if (av_address_i == a_tx_ctrl) begin
			rd_mux[`STXF_MIN_BURST_BIT] = min_burst_reg;
		end else if (av_address_i == a_burst) begin
			rd_mux[3:0] = burst_units_reg;
		end else if (av_address_i == a_port) begin
			rd_mux[7:0] = port_id_reg;
		end else if (av_address_i == a_status) begin
			rd_mux[1:0]                = fifo_state;
			rd_mux[`STXF_ST_LOW_BIT]   = low_speed_select_reg;
			rd_mux[`STXF_ST_OVR_BIT]   = overrun_reg;
			rd_mux[15:8]               = short_cnt_reg;
		end
	end

	// unmapped addresses read zero and ignore writes
	always @(posedge clk_sys_i) begin
		if (reset_i)
			av_readdata_o <= 32'h0;
		else if (av_read_i && av_waitrequest_o)
			av_readdata_o <= rd_mux;
	end

	assign ovr_set = cap_valid_reg & ~buf_in_ready;
	assign ovr_clr = wr_take & av_byteenable_i[0] & (av_address_i == a_status)
		& av_writedata_i[`STXF_ST_OVR_BIT];

	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			low_speed_select_reg <= 1'b0;
			min_burst_reg        <= 1'b0;
			burst_units_reg      <= `STXF_BURST_RST;
			port_id_reg          <= `STXF_PORT_RST;
			overrun_reg          <= 1'b0;
		end else begin
			if (wr_take && av_byteenable_i[0]) begin
				if (av_address_i == a_low_speed)
					low_speed_select_reg <= av_writedata_i[`STXF_LOW_SPEED_BIT];
				else if (av_address_i == a_tx_ctrl)
					min_burst_reg <= av_writedata_i[`STXF_MIN_BURST_BIT];
				else if (av_address_i == a_burst)
					burst_units_reg <= av_writedata_i[3:0];
				else if (av_address_i == a_port)
					port_id_reg <= av_writedata_i[7:0];
			end
			// a word lost in the clearing cycle still leaves the flag set
			overrun_reg <= ovr_set | (overrun_reg & ~ovr_clr);
		end
	end

	// pll hold and bypass follow the low-speed bit so quarter rate is one write
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			pll_hold_pin_o <= 1'b0;
			pll_bypass_o   <= 1'b0;
		end else begin
			pll_hold_pin_o <= low_speed_select_reg;
			pll_bypass_o   <= low_speed_select_reg;
		end
	end

	// fabric clock and pins share the same two-stage latency, so the word
	// seen at the synchronised falling edge is mid-way through its cycle
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			fclk_s1_reg <= 1'b0;
			fclk_s2_reg <= 1'b0;
			fclk_s3_reg <= 1'b0;
			fin_s1_reg  <= {(WORD_W+1){1'b0}};
			fin_s2_reg  <= {(WORD_W+1){1'b0}};
		end else begin
			fclk_s1_reg <= fab_clk_i;
			fclk_s2_reg <= fclk_s1_reg;
			fclk_s3_reg <= fclk_s2_reg;
			fin_s1_reg  <= {fab_wr_i, fab_sop_i, end_of_packet_flag_i, fab_err_i,
				byte_enable_lanes_i, fab_data_i};
			fin_s2_reg  <= fin_s1_reg;
		end
	end

	assign fclk_fall = fclk_s3_reg & ~fclk_s2_reg;

	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			cap_valid_reg <= 1'b0;
			cap_word_reg  <= {WORD_W{1'b0}};
		end else begin
			cap_valid_reg <= fclk_fall & fin_s2_reg[WORD_W];
			if (fclk_fall)
				cap_word_reg <= fin_s2_reg[WORD_W-1:0];
		end
	end

	stxf_buf2 #(
		.W (WORD_W)
	) u_buf (
		.clk_sys_i   (clk_sys_i),
		.reset_i     (reset_i),
		.in_valid_i  (cap_valid_reg),
		.in_ready_o  (buf_in_ready),
		.in_data_i   (cap_word_reg),
		.out_valid_o (buf_out_valid),
		.out_ready_i (load),
		.out_data_o  (buf_out_data),
		.fill_o      (buf_fill)
	);

	assign fab_ready_o = buf_in_ready;

	// quarter rate only paces the beats; width handling is untouched
	assign rate_tick = ~low_speed_select_reg | (rate_cnt_reg == 2'h0);
	assign out_free  = ~tx_valid_o | tx_ready_i;
	assign load      = rate_tick & out_free & buf_out_valid;
	// 16-byte units are BEATS_PER_UNIT beats at every width
	assign seg_beats = {3'h0, burst_units_reg} * BEATS_PER_UNIT;
	assign seg_end   = buf_out_data[DATA_W+BE_W+1]
		| ((beat_cnt_reg + 7'h1) >= seg_beats);
	// without the minimum burst setting, running dry ends the segment early
	assign cut_short = ~min_burst_reg & ~buf_out_valid & out_free
		& (beat_cnt_reg != 7'h0);

	always @(posedge clk_sys_i) begin
		if (reset_i)
			rate_cnt_reg <= 2'h0;
		else if (!low_speed_select_reg || rate_cnt_reg == RATE_LAST)
			rate_cnt_reg <= 2'h0;
		else
			rate_cnt_reg <= rate_cnt_reg + 2'h1;
	end

	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			beat_cnt_reg  <= 7'h0;
			short_cnt_reg <= 8'h0;
			tx_valid_o    <= 1'b0;
			tx_data_o     <= {DATA_W{1'b0}};
			tx_be_o       <= {BE_W{1'b0}};
			tx_sop_o      <= 1'b0;
			tx_eop_o      <= 1'b0;
			tx_err_o      <= 1'b0;
			tx_sos_o      <= 1'b0;
			tx_eos_o      <= 1'b0;
		end else if (load) begin
			tx_valid_o   <= 1'b1;
			tx_data_o    <= buf_out_data[DATA_W-1:0];
			tx_be_o      <= buf_out_data[DATA_W+BE_W-1:DATA_W];
			tx_err_o     <= buf_out_data[DATA_W+BE_W];
			tx_eop_o     <= buf_out_data[DATA_W+BE_W+1];
			tx_sop_o     <= buf_out_data[DATA_W+BE_W+2];
			tx_sos_o     <= (beat_cnt_reg == 7'h0);
			tx_eos_o     <= seg_end;
			beat_cnt_reg <= seg_end ? 7'h0 : beat_cnt_reg + 7'h1;
		end else begin
			if (tx_ready_i)
				tx_valid_o <= 1'b0;
			if (cut_short) begin
				beat_cnt_reg  <= 7'h0;
				short_cnt_reg <= short_cnt_reg + 8'h1;
			end
		end
	end

	// status leaves on the falling edge of the buffered copy so it is
	// settled when the fabric samples on the rising edge
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			rclk_s1_reg      <= 1'b0;
			rclk_s2_reg      <= 1'b0;
			tx_ref_clk_buf_o <= 1'b0;
		end else begin
			rclk_s1_reg      <= tx_reference_clock_i;
			rclk_s2_reg      <= rclk_s1_reg;
			tx_ref_clk_buf_o <= rclk_s2_reg;
		end
	end

	assign rclk_fall = ~rclk_s2_reg & tx_ref_clk_buf_o;

	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			serviced_port_id_o   <= 8'h00;
			port_fifo_state_o    <= `STXF_FS_STARVING;
			port_segment_units_o <= 4'h0;
		end else if (rclk_fall) begin
			serviced_port_id_o   <= port_id_reg;
			port_fifo_state_o    <= fifo_state;
			port_segment_units_o <= burst_units_reg;
		end
	end
endmodule // stxf_top
`default_nettype wire

// ==== verilog/stxf_regs.vh ====
// constants for the transmit fabric write and low-rate block
// assumes byte addressing on the register bus, one 32-bit word per register
// Function
// - core captures all fabric data and control with the fabric's own clock; here sampled on clk_sys_i at the synchronised fab_clk_i fall
// - core drives port id, fifo state, burst size on buffered reference clock
// - configuration and status registers reachable over the system bus
// - low-speed select set to 1 gives quarter-rate operation, 100-200 Mbps
// - 32, 64 and 128-bit width modes behave the same in quarter rate
// - fixed-minimum-burst bit 3 suppresses short segments not caused by eop
// - segments are sixteen times the port's burst-size value in bytes
`ifndef STXF_REGS_VH
`define STXF_REGS_VH

`define STXF_ADDR_W        22
`define STXF_IDX_LOW_SPEED 20'h30915
`define STXF_IDX_TX_CTRL   20'h30916
`define STXF_IDX_BURST     20'h30930
`define STXF_IDX_PORT      20'h30931
`define STXF_IDX_STATUS    20'h30932

`define STXF_LOW_SPEED_BIT 0
`define STXF_MIN_BURST_BIT 3
`define STXF_ST_LOW_BIT    2
`define STXF_ST_OVR_BIT    3

`define STXF_BURST_RST     4'h4
`define STXF_PORT_RST      8'h00
`define STXF_QUARTER_DIV   4
`define STXF_UNIT_BITS     128

`define STXF_FS_STARVING   2'h0
`define STXF_FS_HUNGRY     2'h1
`define STXF_FS_SATISFIED  2'h2

`endif

// ==== verilog/stxf_buf2.v ====
// two-entry elastic buffer with valid/ready on both sides
// assumes a single clock; in_ready_o is registered
`timescale 1ns/1ns
`default_nettype none
module stxf_buf2 #(
	parameter W = 8
) (
	input  wire         clk_sys_i,
	input  wire         reset_i,
	input  wire         in_valid_i,
	output reg          in_ready_o,
	input  wire [W-1:0] in_data_i,
	output wire         out_valid_o,
	input  wire         out_ready_i,
	output wire [W-1:0] out_data_o,
	output wire [1:0]   fill_o
);
	reg  [W-1:0] head_reg;
	reg  [W-1:0] tail_reg;
	reg  [1:0]   count_reg;
	reg  [1:0]   count_next;
	wire         push;
	wire         pop;

	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;
	assign out_valid_o = (count_reg != 2'h0);
	assign out_data_o  = head_reg;
	assign fill_o      = count_reg;

	always @* begin
		count_next = count_reg;
		if (push && !pop)
			count_next = count_reg + 2'h1;
		else if (pop && !push)
			count_next = count_reg - 2'h1;
	end

	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			count_reg  <= 2'h0;
			in_ready_o <= 1'b0;
			head_reg   <= {W{1'b0}};
			tail_reg   <= {W{1'b0}};
		end else begin
			count_reg  <= count_next;
			in_ready_o <= (count_next != 2'h2);
			if (pop) begin
				head_reg <= (count_reg == 2'h2) ? tail_reg : in_data_i;
				if (push && count_reg == 2'h2)
					tail_reg <= in_data_i;
			end else if (push) begin
				if (count_reg == 2'h0)
					head_reg <= in_data_i;
				else
					tail_reg <= in_data_i;
			end
		end
	end
endmodule // stxf_buf2
`default_nettype wire

// ==== verification/stxf_assertions.sv ====
// port-level checks for the transmit fabric write and low-rate block
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
`include "stxf_regs.vh"
module stxf_chk #(
	parameter DATA_W = 128
) (
	input wire logic                    clk_sys_i,
	input wire logic                    reset_i,
	input wire logic [`STXF_ADDR_W-1:0] av_address_i,
	input wire logic                    av_read_i,
	input wire logic                    av_write_i,
	input wire logic [31:0]             av_writedata_i,
	input wire logic                    av_waitrequest_o,
	input wire logic                    tx_valid_o,
	input wire logic                    tx_ready_i,
	input wire logic [DATA_W-1:0]       tx_data_o,
	input wire logic                    tx_eop_o,
	input wire logic                    tx_err_o,
	input wire logic                    tx_eos_o,
	input wire logic                    tx_reference_clock_i,
	input wire logic                    tx_ref_clk_buf_o,
	input wire logic [7:0]              serviced_port_id_o,
	input wire logic [1:0]              port_fifo_state_o,
	input wire logic [3:0]              port_segment_units_o,
	input wire logic                    pll_hold_pin_o,
	input wire logic                    pll_bypass_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	wire logic beat = tx_valid_o && tx_ready_i;
	wire logic ls_wr = av_write_i && !av_waitrequest_o
		&& av_address_i == {`STXF_IDX_LOW_SPEED, 2'h0};
	sequence req_s;
		(av_read_i || av_write_i) && av_waitrequest_o;
	endsequence
	sequence ans_s;
		!av_waitrequest_o ##1 av_waitrequest_o;
	endsequence
	bus_answer_a: assert property (req_s |=> ans_s)
		else $error("bus request not answered after one cycle");
	bus_idle_a: assert property (!av_waitrequest_o |-> $past(av_read_i || av_write_i))
		else $error("bus answer without a request");
	pll_pair_a: assert property (pll_hold_pin_o == pll_bypass_o)
		else $error("pll hold and bypass disagree");
	pll_take_a: assert property (ls_wr |-> ##2 pll_hold_pin_o == $past(av_writedata_i[0], 2))
		else $error("pll control does not follow low speed select");
	tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o
		&& $stable(tx_data_o) && $stable(tx_err_o) && $stable(tx_eop_o))
		else $error("stalled word changed");
	eop_ends_a: assert property (tx_valid_o && tx_eop_o |-> tx_eos_o)
		else $error("end of packet did not close the segment");
	quarter_gap_a: assert property (beat && pll_hold_pin_o |=> (!beat) [*3])
		else $error("quarter rate beats too close");
	status_fall_a: assert property (!$stable({serviced_port_id_o, port_fifo_state_o,
		port_segment_units_o}) |-> !tx_ref_clk_buf_o
		&& ($past(tx_ref_clk_buf_o) || $past(tx_ref_clk_buf_o, 2)))
		else $error("status changed off the buffered clock fall");
	ref_copy_a: assert property (!$past(reset_i) && !$past(reset_i, 2) && !$past(reset_i, 3)
		|-> tx_ref_clk_buf_o == $past(tx_reference_clock_i, 3))
		else $error("buffered reference clock is not a copy of its input");
endmodule // stxf_chk
bind stxf_top stxf_chk #(.DATA_W(DATA_W)) stxf_chk_inst (
	.clk_sys_i, .reset_i, .av_address_i, .av_read_i, .av_write_i, .av_writedata_i,
	.av_waitrequest_o, .tx_valid_o, .tx_ready_i, .tx_data_o, .tx_eop_o, .tx_err_o,
	.tx_eos_o, .tx_reference_clock_i, .tx_ref_clk_buf_o, .serviced_port_id_o, .port_fifo_state_o,
	.port_segment_units_o, .pll_hold_pin_o, .pll_bypass_o
);
`default_nettype wire

// ==== verification/stxf_fab_model.sv ====
// fabric-side writer: sends packets, pads bursts with a dummy word
// assumes ready_i comes from the block; B is the burst size in 16-byte words
`timescale 1ns/1ns
`default_nettype none
module stxf_fab_model #(
	parameter B = 4
) (
	input  wire logic       go_i,
	input  wire logic [3:0] len_i,
	input  wire logic       ready_i,
	output logic            clk_o,
	output logic            wr_o,
	output logic [127:0]    data_o,
	output logic [15:0]     be_o,
	output logic            sop_o,
	output logic            eop_o,
	output logic            err_o,
	output logic            busy_o
);
	logic [3:0] n;
	logic [3:0] pos;
	logic       dum;
	initial begin
		{clk_o, wr_o, sop_o, eop_o, err_o, busy_o, dum} = 7'h0;
		{n, pos} = 8'h0;
		data_o = '0;
		be_o = '0;
	end
	always #80 clk_o = ~clk_o;
	always @(posedge clk_o) begin
		wr_o <= 1'h0;
		data_o <= ~data_o; // idle lines never keep the last word
		be_o <= ~be_o;
		if (!busy_o) begin
			busy_o <= go_i;
			{n, pos, dum} <= 9'h0;
		end else if (ready_i) begin
			wr_o <= 1'h1;
			sop_o <= !dum && n == 4'h0;
			eop_o <= !dum && n == len_i - 4'h1;
			err_o <= dum;
			if (dum) begin
				be_o <= 16'hffff;
				busy_o <= 1'h0;
			end else begin
				data_o <= {16{n, 4'hc}};
				be_o <= (n == len_i - 4'h1) ? 16'h00ff : 16'hffff;
				n <= n + 4'h1;
				pos <= (pos == B - 1) ? 4'h0 : pos + 4'h1;
				if (n == len_i - 4'h1) begin
					dum <= pos != B - 1;
					busy_o <= pos != B - 1;
				end
			end
		end
	end
endmodule // stxf_fab_model
`default_nettype wire

// ==== verification/test_spi4_tx_fabric_write_and_low_rate.sv ====
// register, status and packet tests for the transmit fabric block
// assumes the fabric model drives the write side with burst size 4
`timescale 1ns/1ns
`default_nettype none
`include "stxf_regs.vh"
module test_spi4_tx_fabric_write_and_low_rate;
	logic        clk_sys_i = 1'h0, reset_i = 1'h1, av_read_i = 1'h0, av_write_i = 1'h0;
	logic [21:0] av_address_i = 22'h0;
	logic [31:0] av_writedata_i = 32'h0;
	logic [3:0]  av_byteenable_i = 4'hf, len = 4'h1;
	logic        tx_ready_i = 1'h1, tx_reference_clock_i = 1'h0, go = 1'h0;
	wire logic [31:0]  av_readdata_o;
	wire logic [127:0] fab_data_i, tx_data_o;
	wire logic [15:0]  byte_enable_lanes_i, tx_be_o;
	wire logic [7:0]   serviced_port_id_o;
	wire logic [3:0]   port_segment_units_o;
	wire logic [1:0]   port_fifo_state_o;
	wire logic av_waitrequest_o, fab_clk_i, fab_wr_i, fab_sop_i, end_of_packet_flag_i, fab_err_i;
	wire logic fab_ready_o, tx_valid_o, tx_sop_o, tx_eop_o, tx_err_o, tx_sos_o, tx_eos_o;
	wire logic tx_ref_clk_buf_o, pll_hold_pin_o, pll_bypass_o, busy;
	logic [148:0] q[$];
	int n_fail = 0, checks = 0;
	always #5 clk_sys_i = ~clk_sys_i;
	// edges never meet a rising system clock edge, so sampling has no race
	always #36 tx_reference_clock_i = ~tx_reference_clock_i;
	stxf_top stxf_top_inst (.*);
	stxf_fab_model stxf_fab_model_inst (.go_i(go), .len_i(len), .ready_i(fab_ready_o),
		.clk_o(fab_clk_i), .wr_o(fab_wr_i), .data_o(fab_data_i), .be_o(byte_enable_lanes_i),
		.sop_o(fab_sop_i), .eop_o(end_of_packet_flag_i), .err_o(fab_err_i), .busy_o(busy));
	always @(posedge clk_sys_i) if (tx_valid_o && tx_ready_i) q.push_back({tx_sos_o,
		tx_eos_o, tx_sop_o, tx_eop_o, tx_err_o, tx_be_o, tx_data_o});
	task automatic close_out;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [19:0] idx, input logic [31:0] wd,
		output logic [31:0] rd);
		int i;
		av_address_i <= {idx, 2'h0};
		av_write_i <= w;
		av_read_i <= !w;
		av_writedata_i <= wd;
		i = 0;
		do begin @(posedge clk_sys_i); i++; end while (av_waitrequest_o !== 1'h0 && i < 50);
		if (av_waitrequest_o !== 1'h0) begin n_fail++; close_out; end
		rd = av_readdata_o;
		av_write_i <= 1'h0;
		av_read_i <= 1'h0;
		@(posedge clk_sys_i);
	endtask
	task automatic rchk(input logic [19:0] idx, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'h0, idx, 32'h0, r);
		chk(r, exp);
	endtask
	task automatic send(input logic [3:0] l, input logic stall);
		int i;
		len <= l;
		go <= 1'h1;
		for (i = 0; i < 100 && busy !== 1'h1; i++) @(posedge clk_sys_i);
		go <= 1'h0;
		if (busy !== 1'h1) begin n_fail++; close_out; end
		if (stall) begin
			tx_ready_i <= 1'h0; // far side stalls for a fixed 100 cycles so the fabric gets held off
			repeat (100) @(posedge clk_sys_i);
			tx_ready_i <= 1'h1;
		end
		for (i = 0; i < 3000 && busy !== 1'h0; i++) @(posedge clk_sys_i);
		if (busy !== 1'h0) begin n_fail++; close_out; end
	endtask
	task automatic waitq(input int n);
		for (int i = 0; i < 500 && q.size() < n; i++) @(posedge clk_sys_i);
		if (q.size() < n) begin n_fail++; close_out; end
	endtask
	task automatic pkt(input int l, input int b);
		logic [148:0] v;
		logic [31:0]  e;
		for (int k = 0; k < l; k++) begin
			v = q[b + k];
			e = {k % 4 == 0, k % 4 == 3 || k == l - 1, k == 0, k == l - 1, 1'h0, 27'h0};
			e[15:0] = (k == l - 1) ? 16'h00ff : 16'hffff;
			chk({v[148:144], 11'h0, v[143:128]}, e);
			chk(v[31:0], {4{k[3:0], 4'hc}});
		end
		if ((l - 1) % 4 != 3) begin
			v = q[b + l];
			chk({13'h0, v[148], v[145:128]}, {13'h0, 3'h5, 16'hffff});
		end
	endtask
	initial begin : main
		logic [31:0] r;
		repeat (2) @(posedge clk_sys_i);
		reset_i <= 1'h0;
		@(posedge clk_sys_i);
		rchk(`STXF_IDX_LOW_SPEED, 32'h0);
		rchk(`STXF_IDX_TX_CTRL, 32'h0);
		rchk(`STXF_IDX_BURST, {28'h0, `STXF_BURST_RST});
		rchk(`STXF_IDX_STATUS, 32'h0);
		bus(1'h1, 20'h00001, 32'hffffffff, r);
		rchk(20'h00001, 32'h0);
		av_byteenable_i <= 4'he;
		bus(1'h1, `STXF_IDX_BURST, 32'h9, r);
		av_byteenable_i <= 4'hf;
		rchk(`STXF_IDX_BURST, 32'h4);
		bus(1'h1, `STXF_IDX_PORT, 32'h5a, r);
		rchk(`STXF_IDX_PORT, 32'h5a);
		for (int i = 0; i < 200 && serviced_port_id_o !== 8'h5a; i++) @(posedge clk_sys_i);
		chk({24'h0, serviced_port_id_o}, 32'h5a);
		chk({28'h0, port_segment_units_o}, 32'h4);
		chk({30'h0, port_fifo_state_o}, {30'h0, `STXF_FS_STARVING});
		$display("test registers and status done");
		bus(1'h1, `STXF_IDX_TX_CTRL, 32'h8, r);
		q.delete();
		send(4'h4, 1'h0);
		send(4'h6, 1'h1);
		waitq(11);
		pkt(4, 0);
		pkt(6, 4);
		$display("test full bursts done");
		bus(1'h1, `STXF_IDX_TX_CTRL, 32'h0, r);
		q.delete();
		send(4'h2, 1'h0);
		waitq(3);
		chk({31'h0, q[1][148]}, 32'h1);
		bus(1'h0, `STXF_IDX_STATUS, 32'h0, r);
		chk({31'h0, r[15:8] != 8'h0}, 32'h1);
		$display("test short segments done");
		bus(1'h1, `STXF_IDX_TX_CTRL, 32'h8, r);
		bus(1'h1, `STXF_IDX_LOW_SPEED, 32'h1, r);
		bus(1'h0, `STXF_IDX_STATUS, 32'h0, r);
		chk({30'h0, r[3:2]}, 32'h1);
		chk({30'h0, pll_hold_pin_o, pll_bypass_o}, 32'h3);
		q.delete();
		send(4'h4, 1'h0);
		waitq(4);
		pkt(4, 0);
		bus(1'h1, `STXF_IDX_LOW_SPEED, 32'h0, r);
		@(posedge clk_sys_i);
		chk({30'h0, pll_hold_pin_o, pll_bypass_o}, 32'h0);
		$display("test quarter rate done");
		close_out;
	end
endmodule // test_spi4_tx_fabric_write_and_low_rate
`default_nettype wire
